/* File: verilog/orc_remote_cmd.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module orc_remote_cmd
    import orc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // frame assembly
    input  wire logic [23:0] model_info,
    input  wire logic        remote_cmd_send,
    output logic [23:0]      frame_model_octets,
    output logic             ext_mode,
    output logic [1:0]       remote_op_code,
    // frame events
    input  wire logic        tx_frame_valid,
    input  wire logic        rx_frame_done,
    input  wire logic        rx_crc_ok,
    input  wire logic        rx_opcode_ok,
    input  wire logic        rx_dir_ok,
    // partner status
    input  wire logic [7:0]  partner_status,
    // pins
    input  wire logic        optical_link_pin,
    input  wire logic        center_side_pin
);

    // ========================================================
    // address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    wire wr_ctl      = reg_wr && hit(reg_addr, ADDR_CTL);
    wire wr_rem_addr = reg_wr && hit(reg_addr, ADDR_REM_ADDRESS);
    wire wr_rem_data = reg_wr && hit(reg_addr, ADDR_REM_DATA);
    wire cnt_clear   = reg_wr && hit(reg_addr, ADDR_CNT_CLEAR)
                       && (reg_wdata == CNT_CLEAR_VALUE);

    // ========================================================
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic [1:0] pin_s3_r;
    logic [1:0] pin_f_r;
    logic [1:0] pin_f_nxt;

    assign pin_f_nxt = (pin_s2_r & pin_s3_r) | (~(pin_s2_r ^ pin_s3_r) & pin_s3_r)
                       | ((pin_s2_r ^ pin_s3_r) & pin_f_r);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            pin_s3_r <= 2'h0;
            pin_f_r  <= 2'h0;
        end else begin
            pin_s1_r <= {center_side_pin, optical_link_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r  <= pin_f_nxt;
        end
    end

    wire link_up     = pin_f_r[0];
    wire center_side = pin_f_r[1];

    // ========================================================
    // control register
    logic [1:0] rsv_r;
    logic [1:0] opc_r;
    logic [1:0] mode_r;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rsv_r  <= RSV_RESET;
            opc_r  <= OPC_RESET;
            mode_r <= MODE_RESET;
        end else if (wr_ctl) begin
            // reserved bits stored as written; software keeps them zero
            rsv_r  <= reg_wdata[CTL_RSV_HI:CTL_RSV_LO];
            opc_r  <= reg_wdata[CTL_OPC_HI:CTL_OPC_LO];
            mode_r <= reg_wdata[CTL_MODE_HI:CTL_MODE_LO];
        end
    end

    wire       mode_ext = (mode_r == MODE_EXTENDED);
    wire       mode_nrm = (mode_r == MODE_NORMAL);
    wire [1:0] cap_bits = mode_ext ? CAP_EXTENDED : CAP_NONE;
    wire [7:0] ctl_view = {rsv_r, cap_bits, opc_r, mode_r};

    // ========================================================
    // remote address and data registers
    logic [7:0] rem_addr_r;
    logic [7:0] rem_data_r;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rem_addr_r <= BYTE_ZERO;
        end else if (wr_rem_addr) begin
            rem_addr_r <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rem_data_r <= BYTE_ZERO;
        end else if (wr_rem_data) begin
            rem_data_r <= reg_wdata;
        end
    end

    // ========================================================
    // frame octets 24..26
    // reserved modes are built as normal mode: model info unless remote_cmd_send
    wire [7:0] oct0_nxt = mode_ext ? ctl_view : model_info[OCT0_LO +: 8];
    wire       use_rem  = mode_ext || remote_cmd_send;
    wire [7:0] oct1_nxt = use_rem ? rem_addr_r : model_info[OCT1_LO +: 8];
    wire [7:0] oct2_nxt = use_rem ? rem_data_r : model_info[OCT2_LO +: 8];

    logic [23:0] octets_r;
    logic        ext_mode_r;
    logic [1:0]  op_code_r;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            octets_r   <= OCTETS_RESET;
            ext_mode_r <= 1'b0;
            op_code_r  <= OPC_RESET;
        end else begin
            octets_r   <= {oct2_nxt, oct1_nxt, oct0_nxt};
            ext_mode_r <= mode_ext;
            op_code_r  <= opc_r;
        end
    end

    // ========================================================
    // frame counters
    wire        rx_good = rx_frame_done && rx_crc_ok && rx_opcode_ok && rx_dir_ok;
    logic [7:0] tx_count;
    logic [7:0] rx_count;

    orc_sat_counter u_tx_count (
        .mclk  (mclk),
        .reset (reset),
        .clear (cnt_clear),
        .inc   (tx_frame_valid),
        .count (tx_count)
    );

    orc_sat_counter u_rx_count (
        .mclk  (mclk),
        .reset (reset),
        .clear (cnt_clear),
        .inc   (rx_good),
        .count (rx_count)
    );

    // ========================================================
    // partner status shadow
    orc_shadow_e sh_state_r;
    orc_shadow_e sh_state_nxt;
    logic [7:0]  shadow_r;
    logic [7:0]  shadow_nxt;

    wire [7:0] shadow_default = center_side ? SHADOW_CENTER : SHADOW_TERMINAL;

    always_comb begin
        sh_state_nxt = sh_state_r;
        shadow_nxt   = shadow_r;
        unique case (sh_state_r)
            SH_DEFAULT: begin
                // side strap may settle after reset; follow it until link seen
                shadow_nxt = shadow_default;
                if (link_up) begin
                    shadow_nxt   = partner_status;
                    sh_state_nxt = SH_TRACK;
                end
            end
            SH_TRACK: begin
                // last copy held while the link is down
                if (link_up) begin
                    shadow_nxt = partner_status;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sh_state_r <= SH_DEFAULT;
            shadow_r   <= SHADOW_TERMINAL;
        end else begin
            sh_state_r <= sh_state_nxt;
            shadow_r   <= shadow_nxt;
        end
    end

    // ========================================================
    // read data, valid in the cycle after the strobe only
    logic [7:0] rdata_r;
    logic [7:0] rdata_sel;

    always_comb begin
        rdata_sel = BYTE_ZERO;
        if (hit(reg_addr, ADDR_CTL)) begin
            rdata_sel = ctl_view;
        end else if (hit(reg_addr, ADDR_REM_ADDRESS)) begin
            rdata_sel = rem_addr_r;
        end else if (hit(reg_addr, ADDR_REM_DATA)) begin
            rdata_sel = rem_data_r;
        end else if (hit(reg_addr, ADDR_TX_COUNT)) begin
            rdata_sel = tx_count;
        end else if (hit(reg_addr, ADDR_RX_COUNT)) begin
            rdata_sel = rx_count;
        end else if (hit(reg_addr, ADDR_SHADOW)) begin
            rdata_sel = shadow_r;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_r <= BYTE_ZERO;
        end else begin
            rdata_r <= reg_rd ? rdata_sel : BYTE_ZERO;
        end
    end

    assign reg_rdata          = rdata_r;
    assign frame_model_octets = octets_r;
    assign ext_mode           = ext_mode_r;
    assign remote_op_code     = op_code_r;

    // ========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_ctl_write;
        reg_wr && hit(reg_addr, ADDR_CTL);
    endsequence

    sequence s_ctl_read;
        reg_rd && hit(reg_addr, ADDR_CTL);
    endsequence

    a_cap_field_ext: assert property (
        s_ctl_read |=> (reg_rdata[5:4] == ($past(mode_ext) ? CAP_EXTENDED : CAP_NONE)))
        else $error("capability field wrong");

    a_opcode_readback: assert property (
        s_ctl_write ##1 (s_ctl_read and !reg_wr)
        |=> reg_rdata[CTL_OPC_HI:CTL_OPC_LO] == $past(reg_wdata[CTL_OPC_HI:CTL_OPC_LO], 2))
        else $error("op code readback wrong");

    a_normal_octets: assert property (
        (mode_nrm && !remote_cmd_send) |=> frame_model_octets == $past(model_info))
        else $error("normal mode octets wrong");

    a_ext_octet_ctl: assert property (
        mode_ext |=> frame_model_octets[OCT0_LO +: 8] == $past(ctl_view))
        else $error("extended octet 24 wrong");

    a_remote_addr_octet: assert property (
        (remote_cmd_send && !wr_rem_addr) ##1 !wr_rem_addr
        |-> frame_model_octets[OCT1_LO +: 8] == rem_addr_r)
        else $error("address octet wrong");

    a_remote_data_octet: assert property (
        remote_cmd_send |=> frame_model_octets[OCT2_LO +: 8] == $past(rem_data_r))
        else $error("data octet wrong");

    a_tx_count_step: assert property (
        (tx_frame_valid && !cnt_clear && tx_count != CNT_MAX)
        |=> tx_count == 8'($past(tx_count) + CNT_ONE))
        else $error("tx counter did not step");

    a_rx_bad_ignored: assert property (
        (!rx_good && !cnt_clear) |=> $stable(rx_count))
        else $error("rx counter moved on bad frame");

    a_count_clear: assert property (
        (cnt_clear && !tx_frame_valid && !rx_good)
        |=> (tx_count == CNT_CLEAR_VALUE) && (rx_count == CNT_CLEAR_VALUE))
        else $error("counters not cleared");

    a_shadow_track: assert property (
        link_up |=> shadow_r == $past(partner_status))
        else $error("shadow not tracking partner");

    a_count_saturate: assert property (
        (tx_count == CNT_MAX && !cnt_clear) |=> tx_count == CNT_MAX)
        else $error("tx counter wrapped");

endmodule

/* File: inc/orc_pkg.sv */
package orc_pkg;

    // ========================================================
    // register map
    localparam logic [7:0] ADDR_CNT_CLEAR   = 8'h44;
    localparam logic [7:0] ADDR_CTL         = 8'h4a;
    localparam logic [7:0] ADDR_REM_ADDRESS = 8'h4b;
    localparam logic [7:0] ADDR_REM_DATA    = 8'h4c;
    localparam logic [7:0] ADDR_TX_COUNT    = 8'h4d;
    localparam logic [7:0] ADDR_RX_COUNT    = 8'h4e;
    localparam logic [7:0] ADDR_SHADOW      = 8'h4f;

    // ========================================================
    // control register fields and values
    localparam int         CTL_RSV_HI       = 7;
    localparam int         CTL_RSV_LO       = 6;
    localparam int         CTL_OPC_HI       = 3;
    localparam int         CTL_OPC_LO       = 2;
    localparam int         CTL_MODE_HI      = 1;
    localparam int         CTL_MODE_LO      = 0;
    localparam logic [1:0] RSV_RESET        = 2'h0;
    localparam logic [1:0] OPC_RESET        = 2'h0;
    localparam logic [1:0] MODE_NORMAL      = 2'h0;
    localparam logic [1:0] MODE_EXTENDED    = 2'h2;
    localparam logic [1:0] MODE_RESET       = MODE_EXTENDED;
    localparam logic [1:0] CAP_EXTENDED     = 2'h2;
    localparam logic [1:0] CAP_NONE         = 2'h0;
    localparam logic [1:0] OPC_READ_REPLY   = 2'h0;
    localparam logic [1:0] OPC_READ_REQ     = 2'h1;
    localparam logic [1:0] OPC_WRITE_REPLY  = 2'h2;
    localparam logic [1:0] OPC_WRITE_REQ    = 2'h3;

    // ========================================================
    // other reset values and constants
    localparam logic [7:0] BYTE_ZERO        = 8'h00;
    localparam logic [7:0] CNT_CLEAR_VALUE  = 8'h00;
    localparam logic [7:0] CNT_MAX          = 8'hff;
    localparam logic [7:0] CNT_ONE          = 8'h01;
    localparam logic [7:0] SHADOW_TERMINAL  = 8'h07;
    localparam logic [7:0] SHADOW_CENTER    = 8'h47;
    localparam logic [23:0] OCTETS_RESET    = 24'h000000;

    // ========================================================
    // frame octet byte lanes within the 24 bit group
    localparam int         OCT0_LO          = 0;
    localparam int         OCT1_LO          = 8;
    localparam int         OCT2_LO          = 16;

    // ========================================================
    // shadow state
    typedef enum logic [1:0] {
        SH_DEFAULT = 2'b01,
        SH_TRACK   = 2'b10
    } orc_shadow_e;

endpackage

/* File: verilog/orc_sat_counter.sv */
`timescale 1ns/1ps
module orc_sat_counter
    import orc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // control
    input  wire logic       clear,
    input  wire logic       inc,
    // state
    output logic [7:0]      count
);

    // ========================================================
    // saturating increment
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == CNT_MAX) ? CNT_MAX : 8'(v + CNT_ONE);
    endfunction

    logic [7:0] count_r;
    logic [7:0] count_nxt;

    // clear and event together leave one count: the event is kept
    assign count_nxt = clear ? (inc ? CNT_ONE : CNT_CLEAR_VALUE)
                             : (inc ? sat_inc(count_r) : count_r);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_r <= CNT_CLEAR_VALUE;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

endmodule

/* File: verification/orc_far_end.sv */
`timescale 1ns/1ps
module orc_far_end (
    // clock
    input  wire logic mclk,
    // optical side
    output logic       optical_link_pin,
    output logic [7:0] partner_status,
    // received frame events
    output logic       rx_frame_done,
    output logic       rx_crc_ok,
    output logic       rx_opcode_ok,
    output logic       rx_dir_ok
);
    initial begin
        optical_link_pin = 1'b0;
        partner_status = 8'h00;
        rx_frame_done = 1'b0;
        {rx_crc_ok, rx_opcode_ok, rx_dir_ok} = 3'h0;
    end

    // ========================================================
    // link state, status lines garbled while down
    task automatic set_link(input logic up, input logic [7:0] st);
        @(posedge mclk);
        optical_link_pin <= up;
        if (up) begin
            partner_status <= st;
        end else begin
            // status stays valid until the drop has passed the pin filter
            repeat (8) @(posedge mclk);
            partner_status <= ~partner_status;
        end
    endtask

    // ========================================================
    // one received frame, qualifiers meaningless outside it
    task automatic send_frame(input logic [2:0] q);
        @(posedge mclk);
        rx_frame_done <= 1'b1;
        {rx_crc_ok, rx_opcode_ok, rx_dir_ok} <= q;
        @(posedge mclk);
        rx_frame_done <= 1'b0;
        {rx_crc_ok, rx_opcode_ok, rx_dir_ok} <= ~q;
    endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import orc_pkg::*;
    typedef struct packed {
        logic [7:0] wa;
        logic [7:0] wd;
        logic [7:0] ra;
        logic [7:0] exp;
    } orc_row_s;

    logic        mclk;
    logic        reset;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [23:0] model_info;
    logic        remote_cmd_send;
    logic [23:0] frame_model_octets;
    logic        ext_mode;
    logic [1:0]  remote_op_code;
    logic        tx_frame_valid;
    logic        rx_frame_done;
    logic        rx_crc_ok;
    logic        rx_opcode_ok;
    logic        rx_dir_ok;
    logic [7:0]  partner_status;
    logic        optical_link_pin;
    logic        center_side_pin;
    int          bad_count = 0;
    int          n_checks = 0;
    orc_row_s    r;
    logic [31:0] rows [10] = '{32'h4b_a5_4b_a5, 32'h4c_3c_4c_3c, 32'h4a_02_4a_22,
        32'h4a_06_4a_26, 32'h4a_0a_4a_2a, 32'h4a_0e_4a_2e, 32'h4a_3e_4a_2e,
        32'h4d_55_4d_00, 32'h4f_55_4f_47, 32'h60_77_60_00};

    orc_remote_cmd i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .model_info(model_info), .remote_cmd_send(remote_cmd_send),
        .frame_model_octets(frame_model_octets), .ext_mode(ext_mode),
        .remote_op_code(remote_op_code), .tx_frame_valid(tx_frame_valid),
        .rx_frame_done(rx_frame_done), .rx_crc_ok(rx_crc_ok), .rx_opcode_ok(rx_opcode_ok),
        .rx_dir_ok(rx_dir_ok), .partner_status(partner_status),
        .optical_link_pin(optical_link_pin), .center_side_pin(center_side_pin));

    orc_far_end i_far (.mclk(mclk), .optical_link_pin(optical_link_pin),
        .partner_status(partner_status), .rx_frame_done(rx_frame_done),
        .rx_crc_ok(rx_crc_ok), .rx_opcode_ok(rx_opcode_ok), .rx_dir_ok(rx_dir_ok));

    always #12.5 mclk = ~mclk;

    // ========================================================
    // checking and bus tasks
    task automatic tally_and_finish;
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(nm, {16'h0000, exp}, {16'h0000, v});
    endtask

    task automatic poll(input logic [7:0] exp);
        logic [7:0] v;
        for (int i = 0; i < 20; i++) begin
            rd(ADDR_SHADOW, v);
            if (v === exp) break;
        end
        chk("shadow", {16'h0000, exp}, {16'h0000, v});
        if (v !== exp) tally_and_finish();
    endtask

    task automatic pulse_tx(input int n);
        repeat (n) @(posedge mclk) tx_frame_valid <= 1'b1;
        @(posedge mclk) tx_frame_valid <= 1'b0;
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end

    // ========================================================
    // main sequence
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
        model_info = 24'h332211;
        {remote_cmd_send, tx_frame_valid} = 2'h0;
        // remote command registers are only touched on the center side
        center_side_pin = 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rchk("ctl", ADDR_CTL, 8'h22);
        // reserved control bits always written as zero
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            wr(r.wa, r.wd);
            rchk("row", r.ra, r.exp);
        end
        chk("opcode", {22'h0, OPC_WRITE_REQ}, {22'h0, remote_op_code});
        settle();
        chk("octets", 24'h3ca52e, frame_model_octets);
        chk("ext", 24'h1, {23'h0, ext_mode});
        // write then read with no gap between the strobes
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, ADDR_CTL, 8'h06};
        @(posedge mclk);
        {reg_wr, reg_rd} <= 2'b01;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("ctl b2b", 24'h000026, {16'h0000, reg_rdata});
        wr(ADDR_CTL, 8'h0c);
        settle();
        chk("octets", 24'h332211, frame_model_octets);
        chk("ext", 24'h0, {23'h0, ext_mode});
        @(posedge mclk) remote_cmd_send <= 1'b1;
        settle();
        chk("octets", 24'h3ca511, frame_model_octets);
        @(posedge mclk) remote_cmd_send <= 1'b0;
        // counters, qualifiers, saturation and clear
        pulse_tx(3);
        rchk("tx", ADDR_TX_COUNT, 8'h03);
        for (int q = 0; q < 8; q++) i_far.send_frame(q[2:0]);
        rchk("rx", ADDR_RX_COUNT, 8'h01);
        pulse_tx(260);
        rchk("tx", ADDR_TX_COUNT, CNT_MAX);
        wr(ADDR_CNT_CLEAR, 8'h01);
        rchk("tx", ADDR_TX_COUNT, CNT_MAX);
        wr(ADDR_CNT_CLEAR, 8'h00);
        rchk("tx", ADDR_TX_COUNT, 8'h00);
        rchk("rx", ADDR_RX_COUNT, 8'h00);
        // shadow follows partner only while link is up
        i_far.set_link(1'b1, 8'h5a);
        poll(8'h5a);
        i_far.set_link(1'b1, 8'h6b);
        poll(8'h6b);
        i_far.set_link(1'b0, 8'h00);
        repeat (10) @(posedge mclk);
        rchk("shadow", ADDR_SHADOW, 8'h6b);
        // second reset, still on the center side
        @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rchk("ctl", ADDR_CTL, 8'h22);
        rchk("addr", ADDR_REM_ADDRESS, 8'h00);
        poll(SHADOW_CENTER);
        // third reset on the terminal side, remote registers left alone
        @(posedge mclk);
        reset <= 1'b1;
        center_side_pin <= 1'b0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        poll(SHADOW_TERMINAL);
        tally_and_finish();
    end
endmodule
